/* File: core/stmsr_pkg.sv */
/*
  package for the serializer timing, mode and status register slice:
  offsets, field positions, reset values and timing constants.
  assumes a byte-wide register port driven by the serial control bus front end.
*/
package stmsr_pkg;
  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_CLK_HIGH   = 8'h18;
  localparam logic [7:0] OFF_CLK_LOW    = 8'h19;
  localparam logic [7:0] OFF_DP_CTRL2   = 8'h1A;
  localparam logic [7:0] OFF_BC_ERRCNT  = 8'h1B;
  localparam logic [7:0] OFF_PIN_STAT1  = 8'h1C;
  localparam logic [7:0] OFF_PIN_STAT2  = 8'h1D;
  localparam logic [7:0] OFF_GEN_CTRL   = 8'h04;
  localparam logic [7:0] OFF_PORT_SEL   = 8'h1E;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_CLK_HIGH   = 8'hA1;
  localparam logic [7:0] RST_CLK_LOW    = 8'hA5;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int BIT_SURROUND     = 0;
  localparam int BIT_WIDE_PAYLOAD = 1;
  localparam int BIT_ERR_CLEAR    = 5;
  localparam int BIT_SECOND_PORT  = 1;
  localparam int BIT_STAT1_RSVD   = 4;

  // --------------------------------------------------------------------------
  // timing: extra oscillator periods added to each clock phase
  // --------------------------------------------------------------------------
  localparam logic [8:0] CLK_EXTRA_CYC  = 9'h005;
  localparam logic [7:0] ERR_SAT        = 8'hFF;

  // clock-phase sequencer states
  typedef enum logic [1:0] {STMSR_IDLE, STMSR_HIGH, STMSR_LOW} stmsr_phase_t;
endpackage

/* File: core/stmsr_timer_if.sv */
/*
  interface carrying one phase-timer request and its completion between
  the register slice and its phase timer.
  assumes a single clock domain.
*/
`timescale 1ns/1ns
interface stmsr_timer_if;
  logic       start;    // one-cycle load pulse
  logic [7:0] count;    // programmed setting
  logic       done;     // one-cycle expiry pulse
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface

/* File: core/stmsr_phase_timer.sv */
/*
  phase timer: counts setting + 5 oscillator periods then pulses done.
  assumes start is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
module stmsr_phase_timer
  import stmsr_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  stmsr_timer_if.tmr tif
);
  // --------------------------------------------------------------------------
  // down counter
  // --------------------------------------------------------------------------
  logic [8:0] cnt_reg;  // remaining periods
  logic       run_reg;  // counting

  // load count plus the fixed extra periods, then count to one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 9'h000;
      run_reg <= 1'b0;
    end else if (tif.start) begin
      cnt_reg <= {1'b0, tif.count} + CLK_EXTRA_CYC;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 9'h001;
      if (cnt_reg == 9'h001) begin
        run_reg <= 1'b0;
      end
    end
  end

  assign tif.done = run_reg && (cnt_reg == 9'h001);
endmodule

/* File: core/stmsr_regs.sv */
/*
  serializer register slice: local-bus clock timing settings, data-path mode
  bits, self-test back channel error counter and general pin status.
  assumes a byte register port (addr/wdata/wr/rd) from the serial control bus
  decoder, level pin inputs from outside the clock domain, and error/self-test
  event pulses from same-clock link logic.
*/
`timescale 1ns/1ns
module stmsr_regs
  import stmsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       second_port_select,
  input  wire logic       master_start,
  input  wire logic       master_stop,
  output logic            master_scl_o,
  output logic            master_busy,
  input  wire logic       slave_setup_start,
  output logic            slave_scl_release,
  output logic            wide_payload_select,
  output logic            surround_enable,
  output logic            data_island_force,
  input  wire logic       repeater_mode,
  input  wire logic       inband_surround_valid,
  input  wire logic       inband_surround,
  input  wire logic       built_in_self_test_start,
  input  wire logic       bc_crc_err_port0,
  input  wire logic       bc_crc_err_port1,
  input  wire logic [8:0] general_pin_in,
  input  wire logic [8:0] general_pin_is_input,
  input  wire logic [3:0] remote_pin_in
);
  // --------------------------------------------------------------------------
  // register port decode
  // --------------------------------------------------------------------------
  logic wr_high;   // write to high-time setting
  logic wr_low;    // write to low-time setting
  logic wr_dp;     // write to data path control two
  logic wr_clear;  // write to general control with clear bit set

  assign wr_high  = reg_wr && (reg_addr == OFF_CLK_HIGH);
  assign wr_low   = reg_wr && (reg_addr == OFF_CLK_LOW);
  assign wr_dp    = reg_wr && (reg_addr == OFF_DP_CTRL2);
  assign wr_clear = reg_wr && (reg_addr == OFF_GEN_CTRL) && reg_wdata[BIT_ERR_CLEAR];

  // --------------------------------------------------------------------------
  // clock timing settings
  // --------------------------------------------------------------------------
  logic [7:0] clk_high_reg;  // high phase setting, 40 ns units nominal
  logic [7:0] clk_low_reg;   // low phase setting, also slave data setup

  // both settings are plain read/write bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_high_reg <= RST_CLK_HIGH;
      clk_low_reg  <= RST_CLK_LOW;
    end else begin
      if (wr_high) begin
        clk_high_reg <= reg_wdata;
      end
      if (wr_low) begin
        clk_low_reg <= reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // data path control two
  // --------------------------------------------------------------------------
  logic wide_reg;      // 28-bit payload mode
  logic surround_reg;  // software surround request

  // only bits 1:0 exist; upper written bits are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wide_reg     <= 1'b0;
      surround_reg <= 1'b0;
    end else if (wr_dp) begin
      wide_reg     <= reg_wdata[BIT_WIDE_PAYLOAD];
      surround_reg <= reg_wdata[BIT_SURROUND];
    end
  end

  assign wide_payload_select = wide_reg;
  // repeater in-band detection wins over the software bit while it is valid
  assign surround_enable = (repeater_mode && inband_surround_valid) ? inband_surround : surround_reg;
  // multichannel audio can only travel in data islands
  assign data_island_force = surround_enable;

  // --------------------------------------------------------------------------
  // back channel error counters, one per link
  // --------------------------------------------------------------------------
  logic [7:0] err_cnt_reg [2];  // per-port saturating counts
  logic [1:0] err_evt;          // per-port error pulses

  assign err_evt = {bc_crc_err_port1, bc_crc_err_port0};

  // a clear wins over an error in the same cycle: the test restarts from zero
  for (genvar p = 0; p < 2; p++) begin : g_err
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        err_cnt_reg[p] <= RST_ZERO;
      end else if (built_in_self_test_start || wr_clear) begin
        err_cnt_reg[p] <= RST_ZERO;
      end else if (err_evt[p] && (err_cnt_reg[p] != ERR_SAT)) begin
        err_cnt_reg[p] <= err_cnt_reg[p] + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin input synchronisers: three stages, change taken when 2nd and 3rd agree
  // --------------------------------------------------------------------------
  logic [12:0] pin_s1_reg;   // first stage, read only by second stage
  logic [12:0] pin_s2_reg;   // second stage
  logic [12:0] pin_s3_reg;   // third stage
  logic [12:0] pin_val_reg;  // accepted level
  logic [12:0] pin_raw;      // local pins then remote pins

  assign pin_raw = {remote_pin_in, general_pin_in};

  // pins are asynchronous; filtering stops a metastable sample reaching status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg  <= 13'h0000;
      pin_s2_reg  <= 13'h0000;
      pin_s3_reg  <= 13'h0000;
      pin_val_reg <= 13'h0000;
    end else begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      pin_val_reg <= (pin_s2_reg & pin_s3_reg) | (pin_val_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  // --------------------------------------------------------------------------
  // pin status bytes
  // --------------------------------------------------------------------------
  logic [8:0] local_pin_stat;  // local level, zero when pin not an input
  logic [3:0] low_nibble;      // local or remote pins three to zero
  logic [7:0] stat1;           // status register one image
  logic [7:0] stat2;           // status register two image

  // output-mode pins have no defined status; reporting zero keeps it quiet
  assign local_pin_stat = pin_val_reg[8:0] & general_pin_is_input;
  assign low_nibble = second_port_select ? pin_val_reg[12:9] : local_pin_stat[3:0];
  assign stat1 = {local_pin_stat[7:5], 1'b0, low_nibble};
  assign stat2 = {7'h00, local_pin_stat[8]};

  // --------------------------------------------------------------------------
  // read mux, registered; software must clear port select to see port zero
  // --------------------------------------------------------------------------
  logic [7:0] rd_mux;  // combinational read image

  always_comb begin
    rd_mux = RST_ZERO;
    unique case (reg_addr)
      OFF_CLK_HIGH:  rd_mux = clk_high_reg;
      OFF_CLK_LOW:   rd_mux = clk_low_reg;
      OFF_DP_CTRL2:  rd_mux = {6'h00, wide_reg, surround_reg};
      OFF_BC_ERRCNT: rd_mux = err_cnt_reg[second_port_select ? 1 : 0];
      OFF_PIN_STAT1: rd_mux = stat1;
      OFF_PIN_STAT2: rd_mux = stat2;
      default:       rd_mux = RST_ZERO;
    endcase
  end

  // data held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // local bus master clock sequencer
  // --------------------------------------------------------------------------
  stmsr_phase_t   phase_reg;   // current phase
  stmsr_timer_if  mtif ();     // master phase timer link
  stmsr_timer_if  stif ();     // slave setup timer link

  // settings are sampled at each phase start, so a write mid-phase takes
  // effect from the next phase rather than stretching the current one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= STMSR_IDLE;
    end else begin
      unique case (phase_reg)
        STMSR_IDLE: begin
          if (master_start) begin
            phase_reg <= STMSR_LOW;
          end
        end
        STMSR_LOW: begin
          if (mtif.done) begin
            phase_reg <= STMSR_HIGH;
          end
        end
        STMSR_HIGH: begin
          if (mtif.done) begin
            phase_reg <= master_stop ? STMSR_IDLE : STMSR_LOW;
          end
        end
        default: phase_reg <= STMSR_IDLE;
      endcase
    end
  end

  // low phase timed by the low setting, high phase by the high setting
  assign mtif.start = (phase_reg == STMSR_IDLE && master_start) ||
                      (phase_reg == STMSR_LOW && mtif.done) ||
                      (phase_reg == STMSR_HIGH && mtif.done && !master_stop);
  assign mtif.count = (phase_reg == STMSR_LOW) ? clk_high_reg : clk_low_reg;
  assign master_scl_o = (phase_reg != STMSR_LOW);
  assign master_busy  = (phase_reg != STMSR_IDLE);

  stmsr_phase_timer u_master_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (mtif)
  );

  // --------------------------------------------------------------------------
  // slave data setup before releasing the clock line
  // --------------------------------------------------------------------------
  assign stif.start = slave_setup_start;
  assign stif.count = clk_low_reg;
  assign slave_scl_release = stif.done;

  stmsr_phase_timer u_slave_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (stif)
  );
endmodule

/* File: dv/stmsr_checker.sv */
/*
  port assertions for the timing, mode and status register slice.
  assumes a bind from the testbench top and a single clock domain.
*/
`timescale 1ns/1ns
module stmsr_checker
  import stmsr_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       master_scl_o,
  input wire logic       master_busy,
  input wire logic       slave_setup_start,
  input wire logic       slave_scl_release,
  input wire logic       wide_payload_select,
  input wire logic       surround_enable,
  input wire logic       data_island_force,
  input wire logic       repeater_mode,
  input wire logic       inband_surround_valid,
  input wire logic       inband_surround
);
  // ----------------------------------------
  // shadow settings and run counters
  // ----------------------------------------
  logic [7:0] hi_reg;     // mirrored high setting
  logic [7:0] lo_reg;     // mirrored low setting
  logic       sur_reg;    // mirrored surround bit
  logic [9:0] run_reg;    // length of current scl level
  logic       scl_reg;    // scl level seen at the last edge
  logic [9:0] sl_reg;     // cycles since slave setup start
  logic       sl_on_reg;  // slave wait in progress

  // mirror register writes so timing checks track the live setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_reg  <= RST_CLK_HIGH;
      lo_reg  <= RST_CLK_LOW;
      sur_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFF_CLK_HIGH) begin
        hi_reg <= reg_wdata;
      end
      if (reg_addr == OFF_CLK_LOW) begin
        lo_reg <= reg_wdata;
      end
      if (reg_addr == OFF_DP_CTRL2) begin
        sur_reg <= reg_wdata[BIT_SURROUND];
      end
    end
  end

  // run length of scl and the slave setup wait; scl idles high, so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg   <= 10'h000;
      scl_reg   <= 1'b1;
      sl_reg    <= 10'h000;
      sl_on_reg <= 1'b0;
    end else begin
      scl_reg <= master_scl_o;
      run_reg <= (master_scl_o != scl_reg) ? 10'h001 : run_reg + 10'h001;
      if (slave_setup_start) begin
        sl_reg    <= 10'h001;
        sl_on_reg <= 1'b1;
      end else if (sl_on_reg) begin
        sl_reg <= sl_reg + 10'h001;
        if (sl_reg == {2'b00, lo_reg} + 10'h005) begin
          sl_on_reg <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a read strobe at one offset
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // end of a low phase: the line rises while the master still runs
  sequence s_low_end;
    $rose(master_scl_o) && master_busy;
  endsequence
  // end of a high phase: the line falls after a running cycle
  sequence s_high_end;
    $fell(master_scl_o) && $past(master_busy);
  endsequence
  property p_rd_high;
    s_rd(OFF_CLK_HIGH) |=> reg_rdata == $past(hi_reg);
  endproperty
  property p_rd_low;
    s_rd(OFF_CLK_LOW) |=> reg_rdata == $past(lo_reg);
  endproperty
  property p_dp_rsvd;
    s_rd(OFF_DP_CTRL2) |=> reg_rdata[7:2] == 6'h00;
  endproperty
  property p_wide;
    reg_wr && reg_addr == OFF_DP_CTRL2 |=> wide_payload_select == $past(reg_wdata[BIT_WIDE_PAYLOAD]);
  endproperty
  property p_sur;
    !(repeater_mode && inband_surround_valid) |-> surround_enable == sur_reg;
  endproperty
  property p_ovr;
    repeater_mode && inband_surround_valid |-> surround_enable == inband_surround;
  endproperty
  property p_island;
    data_island_force == surround_enable;
  endproperty
  property p_low_len;
    s_low_end |-> run_reg == {2'b00, lo_reg} + 10'h005;
  endproperty
  property p_high_len;
    s_high_end |-> run_reg == {2'b00, hi_reg} + 10'h005;
  endproperty
  property p_slave;
    slave_scl_release == (sl_on_reg && sl_reg == {2'b00, lo_reg} + 10'h005);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high setting readback wrong");
  a_rd_low: assert property (p_rd_low) else $error("low setting readback wrong");
  a_dp_rsvd: assert property (p_dp_rsvd) else $error("reserved mode bits not zero");
  a_wide: assert property (p_wide) else $error("payload width not updated");
  a_sur: assert property (p_sur) else $error("surround not from register");
  a_ovr: assert property (p_ovr) else $error("in-band surround not applied");
  a_island: assert property (p_island) else $error("transport not tied to surround");
  a_low_len: assert property (p_low_len) else $error("scl low phase length wrong");
  a_high_len: assert property (p_high_len) else $error("scl high phase length wrong");
  a_slave: assert property (p_slave) else $error("slave release timing wrong");
endmodule

/* File: dv/stmsr_bus_partner.sv */
/*
  local bus slave model: watches the master clock line and reports
  the length of the last low and high phases in clock periods.
  assumes the same clock as the register slice.
*/
`timescale 1ns/1ns
module stmsr_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  output logic      [9:0] low_len,
  output logic      [9:0] high_len
);
  logic [9:0] run_reg;  // cycles at current level
  logic       scl_reg;  // level seen last cycle, idles high like the line

  // latch each finished phase on the level change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg  <= 10'h000;
      scl_reg  <= 1'b1;
      low_len  <= 10'h000;
      high_len <= 10'h000;
    end else begin
      scl_reg <= scl;
      run_reg <= (scl != scl_reg) ? 10'h001 : run_reg + 10'h001;
      if (scl && !scl_reg) begin
        low_len <= run_reg;
      end
      if (!scl && scl_reg) begin
        high_len <= run_reg;
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
/*
  self-checking bench for the register slice: byte register reads and
  writes, master and slave clock timing, error counter and pin status.
  assumes core package, interface and modules are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import stmsr_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, second_port_select, master_start, master_stop;
  logic slave_setup_start, repeater_mode, inband_surround_valid, inband_surround;
  logic built_in_self_test_start, bc_crc_err_port0, bc_crc_err_port1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [8:0] general_pin_in, general_pin_is_input;
  logic [3:0] remote_pin_in;
  logic master_scl_o, master_busy, slave_scl_release;
  logic wide_payload_select, surround_enable, data_island_force;
  logic [9:0] low_len, high_len;
  int bad_count, comparisons, n;
  stmsr_regs DUT (.*);
  stmsr_bus_partner PEER (.clk(clk), .rst_n(rst_n), .scl(master_scl_o), .low_len(low_len), .high_len(high_len));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // shared compare, counts every check
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data is registered and stands until the next read, so take it one
  // edge after the load; the task then ends on a rising edge for the next drive
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, reg_rdata});
  endtask
  task automatic stop_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog so a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, second_port_select, master_start, master_stop} = 6'h00;
    {slave_setup_start, repeater_mode, inband_surround_valid, inband_surround} = 4'h0;
    {built_in_self_test_start, bc_crc_err_port0, bc_crc_err_port1} = 3'h0;
    {reg_addr, reg_wdata, remote_pin_in} = 20'h00000;
    {general_pin_in, general_pin_is_input} = 18'h00000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_CLK_HIGH, RST_CLK_HIGH);
    rd(OFF_CLK_LOW, RST_CLK_LOW);
    rd(OFF_DP_CTRL2, 8'h00);
    rd(OFF_BC_ERRCNT, 8'h00);
    wr(OFF_CLK_HIGH, 8'h03);
    wr(OFF_CLK_LOW, 8'h02);
    wr(OFF_BC_ERRCNT, 8'h55);
    wr(OFF_DP_CTRL2, 8'hFF);
    rd(OFF_CLK_HIGH, 8'h03);
    rd(OFF_BC_ERRCNT, 8'h00);
    rd(OFF_DP_CTRL2, 8'h03);
    rd(8'h30, 8'h00);
    chk("wide", 10'h001, {9'h000, wide_payload_select});
    chk("surround", 10'h001, {9'h000, surround_enable});
    chk("island", 10'h001, {9'h000, data_island_force});
    {repeater_mode, inband_surround_valid} <= 2'b11;
    @(posedge clk);
    chk("override", 10'h000, {9'h000, surround_enable});
    {repeater_mode, inband_surround_valid} <= 2'b00;
    wr(OFF_DP_CTRL2, 8'h00);
    // in-band detection can also raise surround over a cleared software bit
    {repeater_mode, inband_surround_valid, inband_surround} <= 3'b111;
    @(posedge clk);
    chk("override on", 10'h001, {9'h000, surround_enable});
    chk("island on", 10'h001, {9'h000, data_island_force});
    {repeater_mode, inband_surround_valid, inband_surround} <= 3'b000;
    // master clocking with short settings, then stop at end of high
    master_start <= 1'b1;
    @(posedge clk);
    master_start <= 1'b0;
    repeat (40) @(posedge clk);
    chk("low len", 10'h007, low_len);
    chk("high len", 10'h008, high_len);
    master_stop <= 1'b1;
    for (n = 0; n < 50 && master_busy !== 1'b0; n++) @(posedge clk);
    chk("stopped", 10'h000, {9'h000, master_busy});
    master_stop <= 1'b0;
    // slave data setup wait uses the low setting too
    slave_setup_start <= 1'b1;
    @(posedge clk);
    slave_setup_start <= 1'b0;
    for (n = 1; n < 50; n++) begin
      @(negedge clk);
      if (slave_scl_release === 1'b1) break;
    end
    chk("setup wait", 10'h007, n[9:0]);
    @(posedge clk);
    // error counter per port, saturation and both clears
    bc_crc_err_port0 <= 1'b1;
    repeat (3) @(posedge clk);
    bc_crc_err_port0 <= 1'b0;
    bc_crc_err_port1 <= 1'b1;
    @(posedge clk);
    bc_crc_err_port1 <= 1'b0;
    rd(OFF_BC_ERRCNT, 8'h03);
    second_port_select <= 1'b1;
    rd(OFF_BC_ERRCNT, 8'h01);
    second_port_select <= 1'b0;
    rd(OFF_BC_ERRCNT, 8'h03);
    bc_crc_err_port0 <= 1'b1;
    repeat (300) @(posedge clk);
    bc_crc_err_port0 <= 1'b0;
    rd(OFF_BC_ERRCNT, ERR_SAT);
    wr(OFF_GEN_CTRL, 8'h20);
    rd(OFF_BC_ERRCNT, 8'h00);
    second_port_select <= 1'b1;
    rd(OFF_BC_ERRCNT, 8'h00);
    bc_crc_err_port1 <= 1'b1;
    @(posedge clk);
    bc_crc_err_port1 <= 1'b0;
    built_in_self_test_start <= 1'b1;
    @(posedge clk);
    built_in_self_test_start <= 1'b0;
    rd(OFF_BC_ERRCNT, 8'h00);
    // pin status: local view, a non-input pin, then the remote view
    second_port_select <= 1'b0;
    general_pin_in <= 9'h1B5; // pin four high must not reach the reserved bit
    general_pin_is_input <= 9'h1FF;
    remote_pin_in <= 4'hA;
    repeat (6) @(posedge clk);
    rd(OFF_PIN_STAT1, 8'hA5);
    rd(OFF_PIN_STAT2, 8'h01);
    general_pin_is_input <= 9'h1FE;
    repeat (6) @(posedge clk);
    rd(OFF_PIN_STAT1, 8'hA4);
    general_pin_is_input <= 9'h1FF;
    second_port_select <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_PIN_STAT1, 8'hAA);
    // reset in mid-run returns the written settings to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_CLK_HIGH, RST_CLK_HIGH);
    rd(OFF_CLK_LOW, RST_CLK_LOW);
    rd(OFF_DP_CTRL2, 8'h00);
    stop_test();
  end
endmodule
bind stmsr_regs stmsr_checker CHK (.*);
